/* rtl/iba_pkg.sv */
// Purpose: shared constants and state codes for the arbitration master
// Assumes: 40 MHz system clock, standard-mode bit timing
// Notes:   rule summary below
//
// Overview of operation
// - a one on SDA is sent by releasing the line, never by driving high
// - expected SDA one but sampled zero means a bus collision
// - collision sets the collision flag and returns the port to idle
// - collision during a byte stops shifting, clears buffer full, frees lines
// - collision during start, restart, stop or acknowledge aborts and frees lines
// - an aborted sequence clears its request bit
// - after collision keep watching the bus without driving it
// - a stop seen while watching sets the serial port interrupt flag
// - a buffer write after collision always starts at the first bit
// - start and stop conditions on the bus raise the interrupt flag
// - start-seen and stop-seen clear on reset and while disabled
// - arbitration is checked in address, data, start, restart, stop and acknowledge
// - buffer full sets on buffer write, clears after eight bits shift out
package iba_pkg;
  localparam int         CLK_PERIOD_NS = 25;
  localparam int         T_HALF_NS     = 5000;
  localparam logic [7:0] HALF_CYC      =
    8'((T_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] BIT_FIRST     = 3'h7;
  localparam logic [2:0] BIT_LAST      = 3'h0;
  localparam logic [1:0] PH_ZERO       = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_RSTART = 3'b010,
    ST_STOP   = 3'b011,
    ST_SHIFT  = 3'b100,
    ST_ACKR   = 3'b101,
    ST_ACKG   = 3'b110
  } iba_state_e;
endpackage

/* rtl/iba_link_if.sv */
// Purpose: bus-monitor results from the link clock domain
// Assumes: every signal here is a flip-flop output of the link domain
// Notes:   receivers must synchronise all four signals
`timescale 1ns/10ps
interface iba_link_if;
  logic sda_lvl;
  logic scl_lvl;
  logic start_tgl;
  logic stop_tgl;
  modport mon (output sda_lvl, output scl_lvl,
               output start_tgl, output stop_tgl);
  modport ctl (input sda_lvl, input scl_lvl,
               input start_tgl, input stop_tgl);
endinterface

/* rtl/iba_bus_mon.sv */
// Purpose: samples SDA/SCL on the link clock, flags start and stop
// Assumes: link clock runs free and much faster than the bus bit rate
// Notes:   events leave as toggles so they survive the crossing
`timescale 1ns/10ps
module iba_bus_mon (
  input  wire logic link_clk_i,
  input  wire logic rst_i,
  input  wire logic sda_i,
  input  wire logic scl_i,
  iba_link_if.mon   lnk
);
  logic [1:0] sda_sy_q;
  logic [1:0] scl_sy_q;
  logic       sda_p_q;
  logic       sta_t_q;
  logic       sto_t_q;
  wire        start_det;
  wire        stop_det;

  // only the second stage and later feed the detectors
  assign start_det = scl_sy_q[1] & sda_p_q & ~sda_sy_q[1];
  assign stop_det  = scl_sy_q[1] & ~sda_p_q & sda_sy_q[1];

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_sy_q <= 2'h3;
      scl_sy_q <= 2'h3;
      sda_p_q  <= 1'b1;
      sta_t_q  <= 1'b0;
      sto_t_q  <= 1'b0;
    end else begin
      sda_sy_q <= {sda_sy_q[0], sda_i};
      scl_sy_q <= {scl_sy_q[0], scl_i};
      sda_p_q  <= sda_sy_q[1];
      sta_t_q  <= sta_t_q ^ start_det;
      sto_t_q  <= sto_t_q ^ stop_det;
    end
  end

  assign lnk.sda_lvl   = sda_sy_q[1];
  assign lnk.scl_lvl   = scl_sy_q[1];
  assign lnk.start_tgl = sta_t_q;
  assign lnk.stop_tgl  = sto_t_q;

  property p_stop_tgl;
    @(posedge link_clk_i) disable iff (rst_i)
    stop_det |=> (sto_t_q != $past(sto_t_q));
  endproperty
  a_stop_tgl: assert property (p_stop_tgl)
    else $error("stop toggle missed");
endmodule

/* rtl/iba_arb_master.sv */
// Purpose: multi-master bit engine with collision detection and abort
// Assumes: open-drain pins, pull-ups outside, bus samples via link clock
// Notes:   no clock stretching support; a stretched high phase skips check
`timescale 1ns/10ps
module iba_arb_master
  import iba_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       link_clk_i,
  input  wire logic       rst_i,
  input  wire logic       enable_i,
  input  wire logic       sda_i,
  input  wire logic       scl_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       buf_wr_i,
  input  wire logic [7:0] buf_data_i,
  input  wire logic       start_set_i,
  input  wire logic       rstart_set_i,
  input  wire logic       stop_set_i,
  input  wire logic       ack_set_i,
  input  wire logic       ack_data_i,
  input  wire logic       bcl_clr_i,
  input  wire logic       int_clr_i,
  output logic            start_req_o,
  output logic            rstart_req_o,
  output logic            stop_req_o,
  output logic            ack_req_o,
  output logic            buffer_full_flag_o,
  output logic            bus_collision_flag_o,
  output logic            serial_port_int_flag_o,
  output logic            start_seen_o,
  output logic            stop_seen_o,
  output logic            ack_status_o
);
  iba_link_if lnk ();

  iba_bus_mon u_mon (
    .link_clk_i (link_clk_i),
    .rst_i      (rst_i),
    .sda_i      (sda_i),
    .scl_i      (scl_i),
    .lnk        (lnk.mon)
  );

  iba_state_e state_q;
  iba_state_e state_d;
  logic [1:0] sda_sy_q;
  logic [1:0] scl_sy_q;
  logic [2:0] sta_sy_q;
  logic [2:0] sto_sy_q;
  logic [1:0] ph_q;
  logic [7:0] cnt_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic       bf_q;
  logic       bcl_q;
  logic       int_q;
  logic       ss_q;
  logic       ps_q;
  logic       rq_sta_q;
  logic       rq_rst_q;
  logic       rq_sto_q;
  logic       rq_ack_q;
  logic       ack_dt_q;
  logic       ackst_q;

  wire sda_s     = sda_sy_q[1];
  wire scl_s     = scl_sy_q[1];
  wire start_evt = sta_sy_q[2] ^ sta_sy_q[1];
  wire stop_evt  = sto_sy_q[2] ^ sto_sy_q[1];
  wire busy      = (state_q != ST_IDLE);
  wire tick      = (cnt_q == HALF_CYC - 8'h01);
  wire is_seq    = (state_q == ST_START) | (state_q == ST_RSTART) |
                   (state_q == ST_STOP);
  wire [1:0] last_ph = (state_q == ST_RSTART || state_q == ST_STOP) ?
                       2'h2 : 2'h1;
  wire ph_end    = tick & (ph_q == last_ph);
  wire scl_hi    = (state_q == ST_START) | (ph_q != PH_ZERO);
  // one is sent by release only, the open-drain output never drives high
  wire sda_low   =
    ((state_q == ST_START)  & (ph_q == 2'h1)) |
    ((state_q == ST_RSTART) & (ph_q == 2'h2)) |
    ((state_q == ST_STOP)   & (ph_q != 2'h2)) |
    ((state_q == ST_SHIFT)  & ~sh_q[7]) |
    ((state_q == ST_ACKG)   & ~ack_dt_q);
  // the received ack slot (ST_ACKR) belongs to the slave, so it is never checked; the sent ack (ST_ACKG) is
  wire chk_ph    =
    ((state_q == ST_START)  & (ph_q == PH_ZERO)) |
    ((state_q == ST_RSTART) & (ph_q == 2'h1)) |
    ((state_q == ST_STOP)   & (ph_q == 2'h2)) |
    ((state_q == ST_SHIFT)  & (ph_q == 2'h1)) |
    ((state_q == ST_ACKG)   & (ph_q == 2'h1));
  // sampled at the end of the high half, so sync lag is long settled
  wire col       = busy & chk_ph & tick & scl_s & ~sda_low
                   & ~sda_s;
  wire seq_done  = ph_end & ~col & (is_seq | (state_q == ST_ACKG));
  wire byte_done = (state_q == ST_SHIFT) & ph_end & ~col & (bit_q == BIT_LAST);
  wire ackr_done = (state_q == ST_ACKR) & ph_end;
  wire load      = buf_wr_i & ~bf_q & enable_i;
  wire clr_sta   = col | (seq_done & (state_q == ST_START));
  wire clr_rst   = col | (seq_done & (state_q == ST_RSTART));
  wire clr_sto   = col | (seq_done & (state_q == ST_STOP));
  wire clr_ack   = col | (seq_done & (state_q == ST_ACKG));
  wire int_set   = seq_done | ackr_done | start_evt | stop_evt;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (!enable_i)    state_d = ST_IDLE;
        else if (rq_sta_q) state_d = ST_START;
        else if (rq_rst_q) state_d = ST_RSTART;
        else if (rq_sto_q) state_d = ST_STOP;
        else if (rq_ack_q) state_d = ST_ACKG;
        else if (bf_q)     state_d = ST_SHIFT;
      end
      ST_SHIFT: if (byte_done) state_d = ST_ACKR;
      ST_START, ST_RSTART, ST_STOP, ST_ACKG, ST_ACKR: begin
        if (ph_end) state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    if (col || !enable_i) state_d = ST_IDLE;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_sy_q <= 2'h3;
      scl_sy_q <= 2'h3;
      sta_sy_q <= 3'h0;
      sto_sy_q <= 3'h0;
    end else begin
      sda_sy_q <= {sda_sy_q[0], lnk.sda_lvl};
      scl_sy_q <= {scl_sy_q[0], lnk.scl_lvl};
      sta_sy_q <= {sta_sy_q[1:0], lnk.start_tgl};
      sto_sy_q <= {sto_sy_q[1:0], lnk.stop_tgl};
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      ph_q    <= PH_ZERO;
      cnt_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_d != state_q || tick) ? 8'h00 : cnt_q + 8'h01;
      if (state_d != state_q || ph_end)
        ph_q <= PH_ZERO;
      else if (tick)
        ph_q <= ph_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_q  <= 8'h00;
      bit_q <= BIT_FIRST;
      bf_q  <= 1'b0;
    end else begin
      if (load) begin
        sh_q  <= buf_data_i;
        bit_q <= BIT_FIRST;
      end else if (state_q == ST_SHIFT && ph_end && !col) begin
        sh_q  <= {sh_q[6:0], 1'b0};
        bit_q <= bit_q - 3'h1;
      end
      // a collision frees the buffer for a fresh write
      bf_q <= load | (bf_q & ~byte_done & ~col & enable_i);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bcl_q    <= 1'b0;
      int_q    <= 1'b0;
      ss_q     <= 1'b0;
      ps_q     <= 1'b0;
      rq_sta_q <= 1'b0;
      rq_rst_q <= 1'b0;
      rq_sto_q <= 1'b0;
      rq_ack_q <= 1'b0;
      ack_dt_q <= 1'b0;
      ackst_q  <= 1'b0;
    end else begin
      bcl_q    <= col | (bcl_q & ~bcl_clr_i);
      int_q    <= int_set | (int_q & ~int_clr_i);
      ss_q     <= enable_i & (start_evt | (ss_q & ~stop_evt));
      ps_q     <= enable_i & (stop_evt | (ps_q & ~start_evt));
      rq_sta_q <= (start_set_i & enable_i) | (rq_sta_q & ~clr_sta);
      rq_rst_q <= (rstart_set_i & enable_i) | (rq_rst_q & ~clr_rst);
      rq_sto_q <= (stop_set_i & enable_i) | (rq_sto_q & ~clr_sto);
      rq_ack_q <= (ack_set_i & enable_i) | (rq_ack_q & ~clr_ack);
      if (ack_set_i)
        ack_dt_q <= ack_data_i;
      if (ackr_done)
        ackst_q <= sda_s;
    end
  end

  // idle never drives, so monitoring after a collision is passive
  assign sda_o    = 1'b0;
  assign scl_o    = 1'b0;
  assign sda_oe_o = busy & sda_low;
  assign scl_oe_o = busy & ~scl_hi;

  assign start_req_o            = rq_sta_q;
  assign rstart_req_o           = rq_rst_q;
  assign stop_req_o             = rq_sto_q;
  assign ack_req_o              = rq_ack_q;
  assign buffer_full_flag_o     = bf_q;
  assign bus_collision_flag_o   = bcl_q;
  assign serial_port_int_flag_o = int_q;
  assign start_seen_o           = ss_q;
  assign stop_seen_o            = ps_q;
  assign ack_status_o           = ackst_q;

  property p_col_idle;
    @(posedge sys_clk_i) disable iff (rst_i)
    col |=> (state_q == ST_IDLE) && bus_collision_flag_o;
  endproperty
  a_col_idle: assert property (p_col_idle)
    else $error("collision did not return to idle");

  property p_col_cause;
    @(posedge sys_clk_i) disable iff (rst_i)
    col |-> scl_s && !sda_s && !sda_oe_o;
  endproperty
  a_col_cause: assert property (p_col_cause)
    else $error("collision without expected-one mismatch");

  property p_col_bf;
    @(posedge sys_clk_i) disable iff (rst_i)
    (col && !buf_wr_i) |=> !buffer_full_flag_o;
  endproperty
  a_col_bf: assert property (p_col_bf)
    else $error("buffer full left set after collision");

  property p_col_release;
    @(posedge sys_clk_i) disable iff (rst_i)
    col |=> (!sda_oe_o && !scl_oe_o) [*2];
  endproperty
  a_col_release: assert property (p_col_release)
    else $error("lines driven after collision");

  property p_col_req;
    @(posedge sys_clk_i) disable iff (rst_i)
    (col && !start_set_i && !stop_set_i) |=> !start_req_o && !stop_req_o;
  endproperty
  a_col_req: assert property (p_col_req)
    else $error("request bit kept after collision");

  property p_stop_int;
    @(posedge sys_clk_i) disable iff (rst_i)
    stop_evt |=> serial_port_int_flag_o && (stop_seen_o || !enable_i);
  endproperty
  a_stop_int: assert property (p_stop_int)
    else $error("stop condition did not raise interrupt");

  property p_load_first;
    @(posedge sys_clk_i) disable iff (rst_i)
    load |=> (bit_q == BIT_FIRST) && buffer_full_flag_o;
  endproperty
  a_load_first: assert property (p_load_first)
    else $error("buffer write did not restart at first bit");

  property p_disable_clr;
    @(posedge sys_clk_i) disable iff (rst_i)
    !enable_i |=> !start_seen_o && !stop_seen_o;
  endproperty
  a_disable_clr: assert property (p_disable_clr)
    else $error("start/stop seen not cleared while disabled");

  property p_bf_clear;
    @(posedge sys_clk_i) disable iff (rst_i)
    byte_done |=> !buffer_full_flag_o ##1 (state_q == ST_ACKR);
  endproperty
  a_bf_clear: assert property (p_bf_clear)
    else $error("buffer full not cleared after eighth bit");
endmodule

/* dv/iba_partner.sv */
// Purpose: other party on the shared bus, open-drain wires with pull-ups
// Assumes: bench tells it when to pull SDA low
// Notes:   data changes wait for SCL low unless a bus condition is asked for
`timescale 1ns/10ps
module iba_partner (
  input  wire logic link_clk_i,
  input  wire logic dut_sda_oe_i,
  input  wire logic dut_scl_oe_i,
  input  wire logic pull_i,
  input  wire logic cond_i,
  output logic      sda_o,
  output logic      scl_o
);
  logic drive_q;

  initial drive_q = 1'b0;
  // wired-and, a one is only a release
  assign sda_o = ~(dut_sda_oe_i | drive_q);
  assign scl_o = ~dut_scl_oe_i;
  // level held while SCL floats high
  always @(posedge link_clk_i) begin
    if (!scl_o || cond_i) begin
      drive_q <= pull_i;
    end
  end
endmodule

/* dv/i2c_master_bus_arbitration_bench.sv */
// Purpose: self-checking bench for the arbitration master
// Assumes: partner pulls SDA to force collisions and bus conditions
// Notes:   expected bit order and collision point come from the data byte
`timescale 1ns/10ps
module i2c_master_bus_arbitration_bench;
  import iba_pkg::*;
  logic sys_clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic enable_i = 1'b0;
  logic buf_wr = 1'b0, bcl_clr = 1'b0, int_clr = 1'b0, ack_data = 1'b0;
  logic pull = 1'b0, cond = 1'b0, busy;
  logic [3:0] set_v = 4'h0;
  wire  [3:0] req;
  wire        sda_lo, scl_lo;
  logic [7:0] buf_data = 8'h00, data;
  logic sda_w, scl_w, sda_oe, scl_oe, bf, bcl, intf, s_seen, p_seen, ack_st;
  logic [31:0] lfsr_q = 32'hCF370BBD;
  logic q_bits[$];
  int failures = 0, num_checks = 0, t, pulses, exp, i;

  always #12.5 sys_clk_i = ~sys_clk_i;
  initial begin
    #7;
    forever #16 link_clk_i = ~link_clk_i;
  end
  always @(posedge scl_oe) pulses = pulses + 1;

  iba_arb_master uut (.sys_clk_i(sys_clk_i), .link_clk_i(link_clk_i),
    .rst_i(rst_i), .enable_i(enable_i), .sda_i(sda_w), .scl_i(scl_w),
    .sda_o(sda_lo), .sda_oe_o(sda_oe), .scl_o(scl_lo), .scl_oe_o(scl_oe),
    .buf_wr_i(buf_wr), .buf_data_i(buf_data), .start_set_i(set_v[0]),
    .rstart_set_i(set_v[1]), .stop_set_i(set_v[2]), .ack_set_i(set_v[3]),
    .ack_data_i(ack_data), .bcl_clr_i(bcl_clr), .int_clr_i(int_clr),
    .start_req_o(req[0]), .rstart_req_o(req[1]), .stop_req_o(req[2]),
    .ack_req_o(req[3]), .buffer_full_flag_o(bf),
    .bus_collision_flag_o(bcl), .serial_port_int_flag_o(intf),
    .start_seen_o(s_seen), .stop_seen_o(p_seen), .ack_status_o(ack_st));
  iba_partner peer (.link_clk_i(link_clk_i), .dut_sda_oe_i(sda_oe),
    .dut_scl_oe_i(scl_oe), .pull_i(pull), .cond_i(cond), .sda_o(sda_w),
    .scl_o(scl_w));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] expv);
    num_checks++;
    if (seen !== expv) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask
  // k 0..3 request bits, 4 buffer write, 5 clear collision, 6 clear int
  task automatic pulse(input int k);
    @(negedge sys_clk_i);
    {int_clr, bcl_clr, buf_wr, set_v} = 7'h01 << k;
    @(negedge sys_clk_i);
    {int_clr, bcl_clr, buf_wr, set_v} = 7'h00;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk_i);
    failures++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    enable_i = 1'b1;
    repeat (20) @(negedge sys_clk_i);
    check("idle", {bf, bcl, intf, req, s_seen}, 8'h00);
    check("open drain", {6'h00, sda_lo, scl_lo}, 8'h00);
    // own start on a free bus
    pulse(0);
    for (t = 0; t < 600 && req[0] !== 1'b0; t++) @(negedge sys_clk_i);
    check("start", {5'h00, req[0], intf, s_seen}, 8'h03);
    repeat (50) @(negedge sys_clk_i);
    pulse(6);
    $display("test start done");
    // byte lost to a master holding SDA low
    data = lfsr_q[7:0] | 8'h01;
    lfsr_q = lfsr_next(lfsr_q);
    pulses = 0;
    pull = 1'b1;
    buf_data = data;
    pulse(4);
    for (t = 0; t < 3700 && bcl !== 1'b1; t++) @(negedge sys_clk_i);
    exp = 1;
    while (!data[8 - exp]) exp++;
    check("lost bit", 8'(pulses), 8'(exp));
    check("abort", {bcl, bf, req, sda_oe, scl_oe}, 8'h80);
    busy = 1'b0;
    for (t = 0; t < 300; t++) begin
      @(negedge sys_clk_i);
      busy = busy | sda_oe | scl_oe;
    end
    check("hands off", {7'h00, busy}, 8'h00);
    $display("test byte collision done");
    // stop then start by the other master while watching
    pulse(6);
    cond = 1'b1;
    pull = 1'b0;
    for (t = 0; t < 100 && intf !== 1'b1; t++) @(negedge sys_clk_i);
    check("stop seen", {6'h00, intf, p_seen}, 8'h03);
    pulse(6);
    pull = 1'b1;
    for (t = 0; t < 100 && intf !== 1'b1; t++) @(negedge sys_clk_i);
    check("start seen", {6'h00, intf, s_seen}, 8'h03);
    $display("test monitor done");
    // each sequence lost to a master that pulls SDA once ours has begun;
    // its stop frees the bus before the next request
    ack_data = 1'b1;
    for (i = 0; i < 4; i++) begin
      pull = 1'b0;
      repeat (20) @(negedge sys_clk_i);
      pulse(5);
      pulse(i);
      pull = 1'b1;
      for (t = 0; t < 1000 && bcl !== 1'b1; t++) @(negedge sys_clk_i);
      check("seq abort", {1'b0, bcl, req, sda_oe, scl_oe}, 8'h40);
    end
    $display("test sequence abort done");
    // bus freed by a stop before the next byte
    pull = 1'b0;
    repeat (20) @(negedge sys_clk_i);
    cond = 1'b0;
    pulse(5);
    pulse(6);
    data = lfsr_q[7:0];
    buf_data = data;
    for (i = 7; i >= 0; i--) q_bits.push_back(data[i]);
    pulse(4);
    check("full", {7'h00, bf}, 8'h01);
    for (i = 0; i < 8; i++) begin
      for (t = 0; t < 500 && scl_oe !== 1'b1; t++) @(negedge sys_clk_i);
      for (t = 0; t < 500 && scl_oe !== 1'b0; t++) @(negedge sys_clk_i);
      repeat (100) @(negedge sys_clk_i);
      check("clock", {7'h00, scl_oe}, 8'h00);
      check("bit", {7'h00, sda_w}, {7'h00, q_bits.pop_front()});
    end
    for (t = 0; t < 1000 && intf !== 1'b1; t++) @(negedge sys_clk_i);
    check("byte end", {5'h00, bf, ack_st, intf}, 8'h03);
    $display("test resend done");
    enable_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    check("disabled", {6'h00, s_seen, p_seen}, 8'h00);
    $display("test disable done");
    end_sim();
  end
endmodule
